// ===== pkg/tapc_pkg.sv
package tapc_pkg;

  localparam int IR_LEN = 5;
  localparam int DATA_LEN = 32;
  localparam int CTRL_LEN = 8;
  localparam int BSR_LEN = 1;

  localparam logic [4:0] OP_EXTEST = 5'h00;
  localparam logic [4:0] OP_SAMPLE = 5'h01;
  localparam logic [4:0] OP_CPU_RESET = 5'h10;
  localparam logic [4:0] OP_SEL_IN = 5'h11;
  localparam logic [4:0] OP_SEL_OUT = 5'h12;
  localparam logic [4:0] OP_SEL_IFULL_IN = 5'h13;
  localparam logic [4:0] OP_SEL_OFULL_OUT = 5'h14;
  localparam logic [4:0] OP_SEL_CTRL = 5'h15;
  localparam logic [4:0] OP_STRESS_TEST_PRIVATE = 5'h0a;
  localparam logic [4:0] OP_PASS_PRIVATE = 5'h0e;
  localparam logic [4:0] OP_HW_TEST_SELECT = 5'h1e;
  localparam logic [4:0] OP_BYPASS = 5'h1f;

  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  localparam int CTRL_OFULL = 0;
  localparam int CTRL_IFULL = 1;
  localparam int CTRL_SLEEPLESS = 2;
  localparam logic [7:0] CTRL_RESET = 8'h04;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc, ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
  } tapc_state_t;

endpackage : tapc_pkg

// ===== verilog/tapc_top.sv
`timescale 1ns/10ps

// Behaviour
// [R1] test logic advances only on test-clock edges
// [R2] state holds while test clock stands
// [R3] mode select sampled on test rising edge
// [R4] serial input sampled on rising edge
// [R5] serial output changes on falling edge
// [R6] output undriven except while shifting
// [R7] serial data passes uninverted, register-length delay
// [R8] power-up in reset, idle on zero
// [R9] parallel stage fixed until update
// [R10] capture, shift n bits, update
// [R11] scan replaces contents by default
// [R12] read-only register ignores update
// [R13] handshake bits: shifted value chooses action
// [R14] instruction register five bits
// [R15] private opcodes undefined, not loaded
// [R16] opcodes 0 and 1 select dummy boundary
// [R17] all ones selects bypass
// [R18] opcode 10000 resets processor
// [R19] opcodes 10001-10101 select mailbox registers
// [R20] hardware test and private opcodes decoded; here only hardware test drives an output, private opcodes fall to bypass
// [R21] no test reset pin, mode select resets
// [R22] instruction loaded before data scan
// [R23] instruction capture loads 01 plus control
// [R24] mailbox data registers 32 bits
// [R25] standard sixteen-state transition table
// [R26] drive output in shift states, lsb first
// [R27] bypass loaded on entering reset
module tapc_top
  import tapc_pkg::*;
#(
  parameter int DATA_W = DATA_LEN
) (
  // system
  input wire logic clk,
  input wire logic rstn,
  // test port pins
  input wire logic testClk,
  input wire logic testModeSel,
  input wire logic testDataIn,
  output logic testDataOut,
  output logic testDataOutEn,
  // processor side mailbox
  input wire logic [DATA_W-1:0] cpuOutData,
  input wire logic cpuOutWrite,
  input wire logic cpuInRead,
  input wire logic cpuSleeplessWrite,
  input wire logic cpuSleeplessVal,
  output logic [DATA_W-1:0] cpuInData,
  output logic [CTRL_LEN-1:0] cpuCtrl,
  output logic cpuDebugIrq,
  output logic cpuResetReq,
  output logic hwTestSelect
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and test-clock edge finder

  logic [2:0] tckSync_q;
  logic [1:0] tmsSync_q;
  logic [1:0] tdiSync_q;
  logic tckRise;
  logic tckFall;

  // [R1] test clock sampled, edges found
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tckSync_q <= 3'h0;
      tmsSync_q <= 2'h3;
      tdiSync_q <= 2'h0;
    end else begin
      tckSync_q <= {tckSync_q[1:0], testClk};
      tmsSync_q <= {tmsSync_q[0], testModeSel};
      tdiSync_q <= {tdiSync_q[0], testDataIn};
    end
  end

  // a pin edge is seen two to three clocks late,
  // so each test-clock half period must span several clocks
  // edges use only the second and third stages; the first stays private
  // [R2] no edge, no change
  assign tckRise = tckSync_q[1] & ~tckSync_q[2];
  assign tckFall = ~tckSync_q[1] & tckSync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // controller state machine

  tapc_state_t state_q;
  tapc_state_t state_d;
  logic tms;
  assign tms = tmsSync_q[1];

  // [R25] standard transition table
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // five rises with mode select high reach reset from any state
  // [R8] power-up lands in reset
  // [R21] only rstn or mode select reset it
  // [R3] mode select steers on rising edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_RESET;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction register

  logic [IR_LEN-1:0] irShift_q;
  logic [IR_LEN-1:0] ir_q;
  logic [CTRL_LEN-1:0] ctrl_q;

  // [R14] five-bit shift and parallel stages
  // [R23] capture 01 plus control bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irShift_q <= 5'h00;
    end else if (tckRise) begin
      if (state_q == ST_CAP_IR) begin
        irShift_q <= {ctrl_q[2:0], IR_CAPTURE_LOW};
      end else if (state_q == ST_SH_IR) begin
        irShift_q <= {tdiSync_q[1], irShift_q[IR_LEN-1:1]};
      end
    end
  end

  // next state is used so bypass is already current on arrival in reset
  // [R27] bypass on reset entry
  // [R9] parallel stage only at update or on reset entry
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ir_q <= OP_BYPASS;
    end else if (tckRise) begin
      if (state_d == ST_RESET) begin
        ir_q <= OP_BYPASS;
      end else if (state_q == ST_UPD_IR) begin
        ir_q <= irShift_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data register select and shift chain

  localparam int CHAIN_W = DATA_W + 1;
  // [R24] mailbox data registers DATA_W wide
  logic [CHAIN_W-1:0] drShift_q;
  logic [DATA_W-1:0] dataIn_q;
  logic [DATA_W-1:0] dataOut_q;
  logic bypass_q;
  logic drTop;
  logic capDr;
  logic shDr;
  logic updDr;
  logic oneBitChain;

  // one-cycle strobes for the data-register states
  assign capDr = tckRise && state_q == ST_CAP_DR;
  assign shDr = tckRise && state_q == ST_SH_DR;
  assign updDr = tckRise && state_q == ST_UPD_DR;

  // length of the chain selected by an opcode; bypass for private ones
  // [R16] dummy boundary register
  // [R17] bypass register
  // [R19] mailbox register selection
  // [R15] unlisted opcodes fall to bypass
  function automatic int chainLen(input logic [IR_LEN-1:0] op);
    unique case (op)
      OP_EXTEST, OP_SAMPLE: chainLen = BSR_LEN;
      OP_SEL_IN, OP_SEL_OUT: chainLen = DATA_W;
      OP_SEL_IFULL_IN, OP_SEL_OFULL_OUT: chainLen = CHAIN_W;
      OP_SEL_CTRL: chainLen = CTRL_LEN;
      default: chainLen = 1;
    endcase
  endfunction : chainLen

  // bypass, dummy boundary and private opcodes share the single cell
  assign oneBitChain = chainLen(ir_q) == 1;

  // [R4] serial in taken at the test rising edge
  always_comb begin
    drTop = tdiSync_q[1];
  end

  // [R10] capture then shift n bits
  // [R7] bit enters at top of selected length
  always_ff @(posedge clk) begin
    if (!rstn) begin
      drShift_q <= '0;
    end else if (capDr) begin
      unique case (ir_q)
        OP_SEL_IN: drShift_q <= {1'b0, dataIn_q};
        OP_SEL_OUT: drShift_q <= {1'b0, dataOut_q};
        OP_SEL_IFULL_IN: drShift_q <= {dataIn_q, ctrl_q[CTRL_IFULL]};
        OP_SEL_OFULL_OUT: drShift_q <= {dataOut_q, ctrl_q[CTRL_OFULL]};
        OP_SEL_CTRL: drShift_q <= {{(CHAIN_W-CTRL_LEN){1'b0}}, ctrl_q};
        default: drShift_q <= '0;
      endcase
    end else if (shDr && !oneBitChain) begin
      drShift_q <= drShift_q >> 1;
      drShift_q[chainLen(ir_q)-1] <= drTop;
    end
  end

  // [R17] single cell captures zero, then passes one bit per rise
  // keeps the wide mailbox chain still while only one bit is selected
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bypass_q <= 1'b0;
    end else if (capDr) begin
      bypass_q <= 1'b0;
    end else if (shDr) begin
      bypass_q <= drTop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mailbox registers and handshake

  // a shifted one in a handshake bit, from the control chain or a flag chain
  // zero there means remember, so a scan reads the flags without harm
  function automatic logic flagOne(input logic [IR_LEN-1:0] op, input logic [CHAIN_W-1:0] sh,
                                   input logic [IR_LEN-1:0] flagOp, input int ctrlBit);
    flagOne = (op == OP_SEL_CTRL && sh[ctrlBit]) || (op == flagOp && sh[0]);
  endfunction : flagOne

  logic irqPulse;
  assign irqPulse = updDr && flagOne(ir_q, drShift_q, OP_SEL_IFULL_IN, CTRL_IFULL);

  // [R11] data-in replaced at update
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dataIn_q <= '0;
    end else if (updDr) begin
      if (ir_q == OP_SEL_IN) begin
        dataIn_q <= drShift_q[DATA_W-1:0];
      end else if (ir_q == OP_SEL_IFULL_IN) begin
        dataIn_q <= drShift_q[CHAIN_W-1:1];
      end
    end
  end

  // [R12] data-out read-only from test port
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dataOut_q <= '0;
    end else if (cpuOutWrite) begin
      dataOut_q <= cpuOutData;
    end
  end

  // [R13] one clears or raises, zero remembers
  // set by processor write wins over a test-port clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (updDr) begin
        if (flagOne(ir_q, drShift_q, OP_SEL_OFULL_OUT, CTRL_OFULL)) begin
          ctrl_q[CTRL_OFULL] <= 1'b0;
        end
        if (ir_q == OP_SEL_CTRL) begin
          ctrl_q[CTRL_SLEEPLESS] <= drShift_q[CTRL_SLEEPLESS];
        end
      end
      if (irqPulse) begin
        ctrl_q[CTRL_IFULL] <= 1'b1;
      end else if (cpuInRead) begin
        ctrl_q[CTRL_IFULL] <= 1'b0;
      end
      if (cpuOutWrite) begin
        ctrl_q[CTRL_OFULL] <= 1'b1;
      end
      if (cpuSleeplessWrite) begin
        ctrl_q[CTRL_SLEEPLESS] <= cpuSleeplessVal;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction side effects

  // [R18] processor reset while selected
  // [R20] hardware test select decoded
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cpuResetReq <= 1'b0;
      hwTestSelect <= 1'b0;
      cpuDebugIrq <= 1'b0;
    end else begin
      cpuResetReq <= ir_q == OP_CPU_RESET;
      hwTestSelect <= ir_q == OP_HW_TEST_SELECT;
      cpuDebugIrq <= irqPulse;
    end
  end

  assign cpuInData = dataIn_q;
  assign cpuCtrl = ctrl_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial output

  // enable follows the state seen at the fall, so it drops half a period after shift
  // [R5] output updates on falling edge
  // [R6] enable only during shifts
  // [R26] lsb of selected stage first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      testDataOut <= 1'b0;
      testDataOutEn <= 1'b0;
    end else if (tckFall) begin
      testDataOutEn <= state_q == ST_SH_IR || state_q == ST_SH_DR;
      testDataOut <= (state_q == ST_SH_IR) ? irShift_q[0] :
                     (oneBitChain ? bypass_q : drShift_q[0]);
    end
  end

endmodule : tapc_top

// ===== sim/tapc_top_asserts.sv
`timescale 1ns/10ps
module tapc_top_asserts
  import tapc_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rstn,
  // test port
  input wire logic testClk,
  input wire logic testDataOut,
  input wire logic testDataOutEn,
  // mailbox
  input wire logic cpuOutWrite,
  input wire logic cpuInRead,
  input wire logic cpuSleeplessWrite,
  input wire logic cpuSleeplessVal,
  input wire logic [CTRL_LEN-1:0] cpuCtrl,
  input wire logic cpuDebugIrq,
  input wire logic cpuResetReq,
  input wire logic hwTestSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sReadNoSet;
    cpuInRead ##1 !cpuDebugIrq;
  endsequence
  sequence sHighLong;
    testClk [*3];
  endsequence
  a_rst_values: assert property ($rose(rstn) |-> cpuCtrl == CTRL_RESET && !testDataOutEn
    && !cpuResetReq && !cpuDebugIrq) else $error("outputs wrong after reset");
  a_tdo_on_fall: assert property ($changed(testDataOut) |-> !$past(testClk)
    && !$past(testClk, 2)) else $error("serial out moved away from a fall");
  a_oe_on_fall: assert property ($changed(testDataOutEn) |-> !$past(testClk)
    && !$past(testClk, 2)) else $error("output enable moved away from a fall");
  a_high_quiet: assert property (sHighLong |-> $stable(testDataOut)
    && $stable(testDataOutEn)) else $error("serial out moved while clock high");
  a_write_sets_ofull: assert property (cpuOutWrite |=> cpuCtrl[CTRL_OFULL])
    else $error("ofull not set by write");
  a_read_clears_ifull: assert property (sReadNoSet |-> !cpuCtrl[CTRL_IFULL])
    else $error("ifull not cleared by read");
  a_sleep_write: assert property (cpuSleeplessWrite |=>
    cpuCtrl[CTRL_SLEEPLESS] == $past(cpuSleeplessVal)) else $error("sleepless not written");
  a_irq_one_cycle: assert property (cpuDebugIrq |=> !cpuDebugIrq)
    else $error("irq longer than one cycle");
  a_ctrl_spare_zero: assert property (cpuCtrl[7:3] == 5'h00)
    else $error("spare control bits set");
  a_one_instr: assert property (!(cpuResetReq && hwTestSelect))
    else $error("two instructions current");
endmodule : tapc_top_asserts

bind tapc_top tapc_top_asserts tapc_top_asserts_i (.clk(clk), .rstn(rstn),
  .testClk(testClk), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn),
  .cpuOutWrite(cpuOutWrite), .cpuInRead(cpuInRead), .cpuSleeplessWrite(cpuSleeplessWrite),
  .cpuSleeplessVal(cpuSleeplessVal), .cpuCtrl(cpuCtrl), .cpuDebugIrq(cpuDebugIrq),
  .cpuResetReq(cpuResetReq), .hwTestSelect(hwTestSelect));

// ===== sim/tapc_probe.sv
`timescale 1ns/10ps
module tapc_probe (
  // pins driven
  output logic testClk,
  output logic testModeSel,
  output logic testDataIn,
  // pins seen
  input wire logic testDataOut,
  input wire logic testDataOutEn
);
  logic lastTdo = 1'h0;
  // released line shows the inverse, no pull on it
  wire tdoLine = testDataOutEn ? testDataOut : ~lastTdo;
  initial begin
    testClk = 1'h0;
    testModeSel = 1'h1;
    testDataIn = 1'h0;
  end
  // one test-clock period; clock stands low between calls
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    testModeSel = tms;
    testDataIn = tdi;
    #62.5 testClk = 1'h1;
    tdo = tdoLine;
    lastTdo = tdoLine;
    #62.5 testClk = 1'h0;
  endtask : tick
  task automatic tapReset;
    logic b;
    repeat (5) tick(1'h1, 1'h0, b);
  endtask : tapReset
  // caller loads a listed instruction first
  task automatic scan(input logic ir, input int n, input logic [32:0] din,
                      output logic [32:0] dout);
    logic b;
    dout = 33'h0;
    tick(1'h0, 1'h0, b);
    tick(1'h1, 1'h0, b);
    if (ir) tick(1'h1, 1'h0, b);
    tick(1'h0, 1'h0, b);
    tick(1'h0, 1'h0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'h1, 1'h0, b);
    tick(1'h0, 1'h0, b);
  endtask : scan
endmodule : tapc_probe

// ===== sim/tapc_top_tb.sv
`timescale 1ns/10ps
module tapc_top_tb
  import tapc_pkg::*;
;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [31:0] cpuOutData = 32'h0;
  logic cpuOutWrite = 1'h0;
  logic cpuInRead = 1'h0;
  logic cpuSleeplessWrite = 1'h0;
  logic cpuSleeplessVal = 1'h0;
  wire testClk, testModeSel, testDataIn, testDataOut, testDataOutEn;
  wire cpuDebugIrq, cpuResetReq, hwTestSelect;
  wire [31:0] cpuInData;
  wire [7:0] cpuCtrl;
  int bad_count = 0;
  int checks_done = 0;
  logic [32:0] w, d, x;
  logic sl;
  logic [7:0] irqCount = 8'h0;
  logic [4:0] ops [3] = '{OP_EXTEST, OP_SAMPLE, OP_BYPASS};
  always #2 clk = ~clk;
  // interrupt is a one-cycle pulse; count them for later checks
  always @(posedge clk) begin
    if (cpuDebugIrq === 1'h1) irqCount <= irqCount + 8'h1;
  end
  tapc_top tapc_top_i (.clk(clk), .rstn(rstn), .testClk(testClk), .testModeSel(testModeSel),
    .testDataIn(testDataIn), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn),
    .cpuOutData(cpuOutData), .cpuOutWrite(cpuOutWrite), .cpuInRead(cpuInRead),
    .cpuSleeplessWrite(cpuSleeplessWrite), .cpuSleeplessVal(cpuSleeplessVal),
    .cpuInData(cpuInData), .cpuCtrl(cpuCtrl), .cpuDebugIrq(cpuDebugIrq),
    .cpuResetReq(cpuResetReq), .hwTestSelect(hwTestSelect));
  tapc_probe tapc_probe_i (.testClk(testClk), .testModeSel(testModeSel),
    .testDataIn(testDataIn), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  function automatic logic [32:0] irCap(input logic [2:0] c);
    return {28'h0, c, 2'h1};
  endfunction : irCap
  task automatic ir(input logic [4:0] op, input logic [2:0] c);
    tapc_probe_i.scan(1'h1, 5, {28'h0, op}, x);
    check(x, irCap(c));
  endtask : ir
  task automatic dr(input int n, input logic [32:0] din);
    tapc_probe_i.scan(1'h0, n, din, x);
  endtask : dr
  task automatic readIn;
    @(posedge clk) cpuInRead <= 1'h1;
    @(posedge clk) cpuInRead <= 1'h0;
    @(posedge clk);
    check(cpuCtrl[CTRL_IFULL], 1'h0);
  endtask : readIn
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(8));
    w = 33'({$urandom, $urandom});
    d = ~w;
    sl = 1'($urandom);
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    check(cpuCtrl, CTRL_RESET);
    check(testDataOutEn, 1'h0);
    dr(33, w);
    check(x, {w[31:0], 1'h0});
    @(posedge clk) cpuSleeplessWrite <= 1'h1;
    cpuSleeplessVal <= sl;
    @(posedge clk) cpuSleeplessWrite <= 1'h0;
    ir(OP_SEL_IN, {sl, 2'h0});
    dr(32, w);
    check(x, 33'h0);
    check(cpuInData, w[31:0]);
    repeat (500) @(posedge clk);
    dr(32, d);
    check(x, w[31:0]);
    check(cpuInData, d[31:0]);
    $display("test inbound end");
    @(posedge clk) cpuOutWrite <= 1'h1;
    cpuOutData <= w[31:0];
    @(posedge clk) cpuOutWrite <= 1'h0;
    ir(OP_SEL_OUT, {sl, 2'h1});
    repeat (2) dr(32, d);
    check(x, w[31:0]);
    ir(OP_SEL_OFULL_OUT, {sl, 2'h1});
    dr(33, {d[31:0], 1'h0});
    check(x, {w[31:0], 1'h1});
    dr(33, {d[31:0], 1'h1});
    check(x, {w[31:0], 1'h1});
    check(cpuCtrl[CTRL_OFULL], 1'h0);
    ir(OP_SEL_IFULL_IN, {sl, 2'h0});
    dr(33, {w[31:0], 1'h1});
    check(x, {d[31:0], 1'h0});
    check(cpuCtrl[CTRL_IFULL], 1'h1);
    check(cpuInData, w[31:0]);
    check(irqCount, 8'h1);
    readIn();
    ir(OP_SEL_CTRL, {sl, 2'h0});
    dr(8, {30'h0, ~sl, 2'h2});
    check(x, {30'h0, sl, 2'h0});
    check(cpuCtrl, {5'h0, ~sl, 2'h2});
    check(irqCount, 8'h2);
    dr(8, {30'h0, sl, 2'h0});
    check(x, {30'h0, ~sl, 2'h2});
    check(cpuCtrl, {5'h0, sl, 2'h2});
    readIn();
    $display("test mailbox end");
    foreach (ops[i]) begin
      ir(ops[i], {sl, 2'h0});
      dr(33, w);
      check(x[32:1], w[31:0]);
      check(testDataOutEn, 1'h0);
    end
    $display("test short paths end");
    ir(OP_HW_TEST_SELECT, {sl, 2'h0});
    check(hwTestSelect, 1'h1);
    ir(OP_CPU_RESET, {sl, 2'h0});
    check(cpuResetReq, 1'h1);
    check(hwTestSelect, 1'h0);
    tapc_probe_i.tapReset();
    check(cpuResetReq, 1'h0);
    dr(33, d);
    check(x, {d[31:0], 1'h0});
    $display("test reset end");
    end_of_test();
  end
endmodule : tapc_top_tb
